// *** verilog/hcu_pkg.sv ***
// Purpose: Shared constants and types of the main control and update block.
// Assumes: One system clock; register fields sit in an 11-bit control word.
// Notes:   Bit positions, masks and reset values are named once here.
package hcu_pkg;

   localparam int          HCU_REG_W          = 11;
   localparam int          HCU_ADDR_W         = 8;
   localparam logic [7:0]  HCU_MAIN_CTRL_OFS  = 8'h01;

   localparam int          HCU_BIT_SOFT_RST   = 0;
   localparam int          HCU_BIT_WIRE4      = 1;
   localparam int          HCU_BIT_LOCK_UPD   = 2;
   localparam int          HCU_BIT_FORCE_UPD  = 3;
   localparam int          HCU_BIT_RGB        = 4;
   localparam int          HCU_BIT_CLK_INV    = 5;
   localparam int          HCU_BIT_DREF_B     = 6;
   localparam int          HCU_BIT_BYPASS     = 7;
   localparam int          HCU_BIT_RSVD       = 8;
   localparam int          HCU_BIT_PWRDWN     = 9;
   localparam int          HCU_BIT_PORT_B     = 10;

   localparam logic [10:0] HCU_CTRL_RST       = 11'h000;
   // Bits that survive a soft reset
   localparam logic [10:0] HCU_PRESERVE_MASK  = 11'h6F2;
   // Bits stored from a write; reserved bit always reads zero
   localparam logic [10:0] HCU_WRITE_MASK     = 11'h6F7;

   localparam int          HCU_PIX_W          = 24;
   localparam int          HCU_SYNC_W         = 3;
   localparam int          HCU_BYPASS_DELAY   = 2;
   localparam int          HCU_NUM_PARAM      = 48;
   localparam int          HCU_PARAM_W        = 8;

   typedef enum logic [1:0] {
      HCU_XF_IDLE = 2'b00,
      HCU_XF_COPY = 2'b01,
      HCU_XF_DONE = 2'b11
   } hcu_xfer_state_t;

endpackage : hcu_pkg

// *** verilog/hcu_xfer_if.sv ***
// Purpose: Carries update requests to and completion pulses from the transfer unit.
// Assumes: Both ends on clk_sys_i.
// Notes:   Completion pulses last one cycle.
`timescale 1ns/100ps
interface hcu_xfer_if;
   logic req_force;
   logic req_lock;
   logic lock_event;
   logic soft_rst;
   logic done_force;
   logic done_lock;

   modport ctrl (
      output req_force,
      output req_lock,
      output lock_event,
      output soft_rst,
      input  done_force,
      input  done_lock
   );
   modport xfer (
      input  req_force,
      input  req_lock,
      input  lock_event,
      input  soft_rst,
      output done_force,
      output done_lock
   );
endinterface : hcu_xfer_if

// *** verilog/hcu_param_xfer.sv ***
// Purpose: Copies the pending parameter set into the active set on request.
// Assumes: Pending set is stable while a copy is in progress.
// Notes:   A forced request is served before a lock-synchronised one.
`timescale 1ns/100ps
module hcu_param_xfer
   import hcu_pkg::*;
#(
   parameter int NUM_PARAM = HCU_NUM_PARAM,
   parameter int PARAM_W   = HCU_PARAM_W
) (
   input  wire logic                         clk_sys_i,
   input  wire logic                         nrst_i,
   hcu_xfer_if.xfer                          xf,
   input  wire logic [NUM_PARAM*PARAM_W-1:0] pending_set_i,
   output logic      [NUM_PARAM*PARAM_W-1:0] active_set_o
);
   hcu_xfer_state_t    state_q;
   logic               kind_force_q;
   logic               done_force_q;
   logic               done_lock_q;
   logic [PARAM_W-1:0] active_q [NUM_PARAM];

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q      <= HCU_XF_IDLE;
         kind_force_q <= 1'b0;
      end else begin
         case (state_q)
            HCU_XF_IDLE: begin
               if (xf.soft_rst) begin
                  state_q <= HCU_XF_IDLE;
               end else if (xf.req_force) begin
                  state_q      <= HCU_XF_COPY;
                  kind_force_q <= 1'b1;
               end else if (xf.req_lock && xf.lock_event) begin
                  state_q      <= HCU_XF_COPY;
                  kind_force_q <= 1'b0;
               end
            end
            HCU_XF_COPY: state_q <= HCU_XF_DONE;
            HCU_XF_DONE: state_q <= HCU_XF_IDLE;
            default:     state_q <= HCU_XF_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done_force_q <= 1'b0;
         done_lock_q  <= 1'b0;
      end else begin
         done_force_q <= (state_q == HCU_XF_COPY) && kind_force_q;
         done_lock_q  <= (state_q == HCU_XF_COPY) && !kind_force_q;
      end
   end

   assign xf.done_force = done_force_q;
   assign xf.done_lock  = done_lock_q;

   genvar g;
   generate
      for (g = 0; g < NUM_PARAM; g++) begin : g_word
         always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               active_q[g] <= '0;
            end else if (state_q == HCU_XF_COPY) begin
               active_q[g] <= pending_set_i[g*PARAM_W +: PARAM_W];
            end
         end
         assign active_set_o[g*PARAM_W +: PARAM_W] = active_q[g];
      end
   endgenerate

endmodule : hcu_param_xfer

// *** verilog/hcu_bypass_pipe.sv ***
// Purpose: Two-stage display data path choosing passthrough or scaled video.
// Assumes: Port A data and controls are synchronous to clk_sys_i.
// Notes:   Passthrough latency is two clocks; normal path latency is one.
`timescale 1ns/100ps
module hcu_bypass_pipe #(
   parameter int DATA_W = 48
) (
   input  wire logic              clk_sys_i,
   input  wire logic              nrst_i,
   input  wire logic              bypass_en_i,
   input  wire logic [DATA_W-1:0] pass_data_i,
   input  wire logic [DATA_W-1:0] norm_data_i,
   output logic      [DATA_W-1:0] data_o
);
   logic [DATA_W-1:0] stage1_q;
   logic [DATA_W-1:0] data_q;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1_q <= '0;
      end else begin
         stage1_q <= pass_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_q <= '0;
      end else if (bypass_en_i) begin
         data_q <= stage1_q;
      end else begin
         data_q <= norm_data_i;
      end
   end

   assign data_o = data_q;

endmodule : hcu_bypass_pipe

// *** verilog/hcu_main_ctrl.sv ***
// Purpose: Main control register with parameter update, clock and bypass control.
// Assumes: Host interface controller delivers decoded register writes and reads.
// Notes:   Pixel and reference clocks are sampled as levels on clk_sys_i.
//          Pin clocks must stay well below half of clk_sys_i or they alias.
//          Clock source switching is not glitch-free; soft reset follows it.
//
// Overview of operation
// - Lock-synchronised update bit copies pending set to active set at next lock event.
// - Lock-synchronised update bit clears on soft reset or after its transfer or a forced transfer.
// - Writing 1 to immediate update copies pending set at once; 0 does nothing.
// - Immediate update bit clears on soft reset or after forced transfer.
// - Colour format bit: 0 YUV on port B, 1 RGB on selected port.
// - Colour format bit survives soft reset; hard reset clears it.
// - Clock polarity bit passes selected input clock straight or inverted.
// - Polarity bit survives soft reset; host soft-resets after changing it.
// - Display clock source bit picks reference clock A or B.
// - Display clock source bit survives soft reset; hard reset clears it.
// - Passthrough off: output scaled video with overlay and own timing.
// - Passthrough on: port A pixels and controls appear two clocks later.
// - Passthrough on: display clock no longer from either reference clock.
// - Passthrough on: display clock is a delayed port A pixel clock.
// - Passthrough bit survives soft reset; host soft-resets after changing it.
// - Soft reset trigger self-clears; soft reset clears all unpreserved bits.
`timescale 1ns/100ps
module hcu_main_ctrl
   import hcu_pkg::*;
#(
   parameter int NUM_PARAM = HCU_NUM_PARAM,
   parameter int PARAM_W   = HCU_PARAM_W,
   parameter int PIX_W     = HCU_PIX_W,
   parameter int SYNC_W    = HCU_SYNC_W
) (
   input  wire logic                         clk_sys_i,
   input  wire logic                         nrst_i,

   // Register access from the host interface controller
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   input  wire logic [HCU_ADDR_W-1:0]        reg_addr_i,
   input  wire logic [HCU_REG_W-1:0]         reg_wdata_i,
   output logic      [HCU_REG_W-1:0]         reg_rdata_o,
   output logic                              reg_rvalid_o,

   // Parameter sets
   input  wire logic                         lock_event_i,
   input  wire logic [NUM_PARAM*PARAM_W-1:0] pending_set_i,
   output logic      [NUM_PARAM*PARAM_W-1:0] active_set_o,

   // Clock pins, sampled as levels
   input  wire logic                         port_a_pixel_clock_i,
   input  wire logic                         port_b_pixel_clock_i,
   input  wire logic                         display_ref_clock_a_i,
   input  wire logic                         display_ref_clock_b_i,
   output logic                              input_pixel_clock_o,
   output logic                              display_pixel_clock_o,

   // Input routing
   output logic                              input_rgb_mode_o,
   output logic                              input_port_b_sel_o,

   // Display data path
   input  wire logic [2*PIX_W-1:0]           port_a_data_i,
   input  wire logic [SYNC_W-1:0]            port_a_ctrl_i,
   input  wire logic [2*PIX_W-1:0]           scaled_data_i,
   input  wire logic [SYNC_W-1:0]            timing_gen_ctrl_i,
   output logic      [2*PIX_W-1:0]           display_data_o,
   output logic      [SYNC_W-1:0]            display_ctrl_o,
   output logic                              display_bypass_o,

   // Device-wide control
   output logic                              soft_reset_o,
   output logic                              wire4_mode_o,
   output logic                              power_down_o
);
   localparam int CLK_N  = 4;
   // Position of each pin in clk_pins
   localparam int PIN_A  = 0;
   localparam int PIN_B  = 1;
   localparam int REF_A  = 2;
   localparam int REF_B  = 3;
   localparam int PIPE_W = 2*PIX_W + SYNC_W;

   logic [HCU_REG_W-1:0] ctrl_q;
   logic [HCU_REG_W-1:0] ctrl_d;
   logic                 wr_hit;
   logic                 soft_exec;
   logic                 force_keep;
   logic                 soft_rst_q;
   logic [HCU_REG_W-1:0] rdata_q;
   logic                 rvalid_q;

   // Clock and routing path
   logic [CLK_N-1:0]     clk_pins;
   logic [CLK_N-1:0]     clk_meta_q;
   logic [CLK_N-1:0]     clk_sync_q;
   logic                 port_a_clk_dly_q;
   logic                 in_clk_q;
   logic                 disp_clk_q;
   logic                 rgb_mode_q;
   logic                 port_b_sel_q;
   logic                 in_clk_sel;
   logic                 disp_clk_sel;
   logic [PIPE_W-1:0]    pipe_out;

   // Requests to and completions from the transfer unit
   hcu_xfer_if xf_if ();

   assign wr_hit    = reg_wr_i && (reg_addr_i == HCU_MAIN_CTRL_OFS);
   // Trigger acts in the cycle after it is written
   assign soft_exec = ctrl_q[HCU_BIT_SOFT_RST];
   // Forced request outlives a zero write until served or reset
   assign force_keep = ctrl_q[HCU_BIT_FORCE_UPD] && !soft_exec && !xf_if.done_force;

   // Control register next value
   always_comb begin
      // Hardware clears first, host write last
      ctrl_d = ctrl_q;
      if (soft_exec) begin
         ctrl_d = ctrl_q & HCU_PRESERVE_MASK;
      end
      if (xf_if.done_lock) begin
         ctrl_d[HCU_BIT_LOCK_UPD] = 1'b0;
      end

      if (xf_if.done_force) begin
         ctrl_d[HCU_BIT_FORCE_UPD] = 1'b0;
         ctrl_d[HCU_BIT_LOCK_UPD]  = 1'b0;
      end

      // Host write wins over hardware clears,
      // so a request written in a clearing cycle is not lost
      if (wr_hit) begin
         ctrl_d = (ctrl_d & ~HCU_WRITE_MASK) | (reg_wdata_i & HCU_WRITE_MASK);
         ctrl_d[HCU_BIT_FORCE_UPD] = reg_wdata_i[HCU_BIT_FORCE_UPD] | force_keep;
      end

      // Reserved bit never stored
      ctrl_d[HCU_BIT_RSVD] = 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= HCU_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Lags the trigger by one cycle; both last one cycle
   // soft reset pulse
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= soft_exec;
      end
   end

   // Read-back of the control register
   // Other addresses answer zero; every read gets rvalid
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i && (reg_addr_i == HCU_MAIN_CTRL_OFS)) begin
            rdata_q <= ctrl_q;
         end else begin
            rdata_q <= '0;
         end
      end
   end

   // Update requests to the transfer unit
   // Soft reset holds an idle unit; a running copy completes
   assign xf_if.req_force  = ctrl_q[HCU_BIT_FORCE_UPD];
   assign xf_if.req_lock   = ctrl_q[HCU_BIT_LOCK_UPD];
   assign xf_if.lock_event = lock_event_i;
   assign xf_if.soft_rst   = soft_exec;

   // Copies pending to active on either request
   hcu_param_xfer #(
      .NUM_PARAM (NUM_PARAM),
      .PARAM_W   (PARAM_W)
   ) u_xfer (
      .clk_sys_i     (clk_sys_i),
      .nrst_i        (nrst_i),
      .xf            (xf_if.xfer),
      .pending_set_i (pending_set_i),
      .active_set_o  (active_set_o)
   );

   // Clock pin synchronisers
   // Pins are asynchronous; only the second stage is read
   assign clk_pins = {display_ref_clock_b_i, display_ref_clock_a_i,
                      port_b_pixel_clock_i, port_a_pixel_clock_i};

   genvar g;
   generate
      for (g = 0; g < CLK_N; g++) begin : g_clk_sync
         always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
               clk_meta_q[g] <= 1'b0;
               clk_sync_q[g] <= 1'b0;
            end else begin
               clk_meta_q[g] <= clk_pins[g];
               clk_sync_q[g] <= clk_meta_q[g];
            end
         end
      end
   endgenerate

   // Reset selects port B, as for YUV after hard reset
   // input port routing
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rgb_mode_q   <= 1'b0;
         port_b_sel_q <= 1'b1;
      end else begin
         rgb_mode_q   <= ctrl_q[HCU_BIT_RGB];
         port_b_sel_q <= !ctrl_q[HCU_BIT_RGB] || ctrl_q[HCU_BIT_PORT_B];
      end
   end

   // Source follows the register at once; a soft reset follows a change
   assign in_clk_sel = (!ctrl_q[HCU_BIT_RGB] || ctrl_q[HCU_BIT_PORT_B])
                       ? clk_sync_q[PIN_B] : clk_sync_q[PIN_A];

   // input clock polarity
   // Inversion is a plain XOR of the sampled level
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_clk_q <= 1'b0;
      end else begin
         in_clk_q <= in_clk_sel ^ ctrl_q[HCU_BIT_CLK_INV];
      end
   end

   // Extra stage delays the clock along with the data
   // delayed port A clock
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         port_a_clk_dly_q <= 1'b0;
      end else begin
         port_a_clk_dly_q <= clk_sync_q[PIN_A];
      end
   end

   // display clock source
   // Not glitch-free; a soft reset must follow a change
   assign disp_clk_sel = ctrl_q[HCU_BIT_DREF_B] ? clk_sync_q[REF_B] : clk_sync_q[REF_A];

   // bypass clock source
   // Bypass takes port A clock, else the reference choice
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         disp_clk_q <= 1'b0;
      end else if (ctrl_q[HCU_BIT_BYPASS]) begin
         disp_clk_q <= port_a_clk_dly_q;
      end else begin
         disp_clk_q <= disp_clk_sel;
      end
   end

   // Data and controls share the pipe so they stay aligned
   // two clock passthrough
   hcu_bypass_pipe #(
      .DATA_W (PIPE_W)
   ) u_pipe (
      .clk_sys_i   (clk_sys_i),
      .nrst_i      (nrst_i),
      .bypass_en_i (ctrl_q[HCU_BIT_BYPASS]),
      .pass_data_i ({port_a_ctrl_i, port_a_data_i}),
      .norm_data_i ({timing_gen_ctrl_i, scaled_data_i}),
      .data_o      (pipe_out)
   );

   // Every output comes straight from a flip-flop
   assign reg_rdata_o           = rdata_q;
   assign reg_rvalid_o          = rvalid_q;
   assign input_pixel_clock_o   = in_clk_q;
   assign display_pixel_clock_o = disp_clk_q;
   assign input_rgb_mode_o      = rgb_mode_q;
   assign input_port_b_sel_o    = port_b_sel_q;
   assign display_data_o        = pipe_out[2*PIX_W-1:0];
   assign display_ctrl_o        = pipe_out[PIPE_W-1:2*PIX_W];
   assign display_bypass_o      = ctrl_q[HCU_BIT_BYPASS];
   assign soft_reset_o          = soft_rst_q;
   assign wire4_mode_o          = ctrl_q[HCU_BIT_WIRE4];
   assign power_down_o          = ctrl_q[HCU_BIT_PWRDWN];

endmodule : hcu_main_ctrl

// *** sim/hcu_main_ctrl_props.sv ***
// Purpose: Port-level checks of the main control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Data path checks start three cycles after reset release.
`timescale 1ns/100ps
module hcu_main_ctrl_props
   import hcu_pkg::*;
#(
   parameter int NUM_PARAM = HCU_NUM_PARAM,
   parameter int PARAM_W   = HCU_PARAM_W,
   parameter int PIX_W     = HCU_PIX_W,
   parameter int SYNC_W    = HCU_SYNC_W
) (
   input wire logic                         clk_sys_i,
   input wire logic                         nrst_i,
   input wire logic                         reg_wr_i,
   input wire logic                         reg_rd_i,
   input wire logic [HCU_ADDR_W-1:0]        reg_addr_i,
   input wire logic [HCU_REG_W-1:0]         reg_wdata_i,
   input wire logic [HCU_REG_W-1:0]         reg_rdata_o,
   input wire logic                         reg_rvalid_o,
   input wire logic [NUM_PARAM*PARAM_W-1:0] pending_set_i,
   input wire logic [NUM_PARAM*PARAM_W-1:0] active_set_o,
   input wire logic [2*PIX_W-1:0]           port_a_data_i,
   input wire logic [2*PIX_W-1:0]           scaled_data_i,
   input wire logic [2*PIX_W-1:0]           display_data_o,
   input wire logic                         display_bypass_o,
   input wire logic                         input_rgb_mode_o,
   input wire logic                         input_port_b_sel_o,
   input wire logic                         soft_reset_o
);
   logic [1:0] up_q;
   logic       ctrl_wr;
   assign ctrl_wr = reg_wr_i && (reg_addr_i == HCU_MAIN_CTRL_OFS);
   // Cycles since reset release, so pipeline history is valid
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered next cycle");
   rd_unmapped_a: assert property (reg_rd_i && reg_addr_i != HCU_MAIN_CTRL_OFS
      |=> reg_rdata_o == 11'h000) else $error("unmapped read not zero");
   force_copy_a: assert property (
      ctrl_wr && reg_wdata_i[HCU_BIT_FORCE_UPD] |-> ##[1:5] active_set_o == pending_set_i)
      else $error("forced copy missing");
   soft_trig_a: assert property (
      ctrl_wr && reg_wdata_i[HCU_BIT_SOFT_RST] |-> ##[1:3] soft_reset_o)
      else $error("soft reset not issued");
   soft_once_a: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset not self cleared");
   soft_keep_a: assert property (soft_reset_o |-> $stable(input_rgb_mode_o)
      && $stable(display_bypass_o) && $stable(input_port_b_sel_o))
      else $error("preserved bit lost in soft reset");
   yuv_route_a: assert property (
      !input_rgb_mode_o && !$past(input_rgb_mode_o) |-> input_port_b_sel_o)
      else $error("yuv input not on port b");
   bypass_path_a: assert property (up_q == 2'h3 && display_bypass_o
      && $past(display_bypass_o) && $past(display_bypass_o, 2)
      |-> display_data_o == $past(port_a_data_i, 2)) else $error("bypass latency wrong");
   normal_path_a: assert property (up_q == 2'h3 && !display_bypass_o
      && !$past(display_bypass_o) && !$past(display_bypass_o, 2)
      |-> display_data_o == $past(scaled_data_i)) else $error("scaled path wrong");
   cover property (ctrl_wr && reg_wdata_i[HCU_BIT_FORCE_UPD]);
   cover property (soft_reset_o && input_rgb_mode_o);
   cover property (up_q == 2'h3 && display_bypass_o ##3 display_bypass_o);
endmodule : hcu_main_ctrl_props

bind hcu_main_ctrl hcu_main_ctrl_props #(
   .NUM_PARAM(NUM_PARAM), .PARAM_W(PARAM_W), .PIX_W(PIX_W), .SYNC_W(SYNC_W)
) props_inst (.*);

// *** sim/hcu_host_model.sv ***
// Purpose: Host controller issuing decoded register writes and reads.
// Assumes: Strobes change on the falling clock edge.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/100ps
module hcu_host_model
   import hcu_pkg::*;
(
   input  wire logic                  clk_sys_i,
   input  wire logic [HCU_REG_W-1:0]  rdata_i,
   input  wire logic                  rvalid_i,
   output logic                       wr_o,
   output logic                       rd_o,
   output logic      [HCU_ADDR_W-1:0] addr_o,
   output logic      [HCU_REG_W-1:0]  wdata_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 11'h000;
   end
   task automatic wr(input logic [7:0] a, input logic [10:0] d);
      @(negedge clk_sys_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_sys_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [10:0] d);
      @(negedge clk_sys_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_sys_i);
      rd_o = 1'b0;
      addr_o = ~a;
      for (int n = 0; n < 4 && rvalid_i !== 1'b1; n++) begin
         @(negedge clk_sys_i);
      end
      d = rdata_i;
   endtask : rd
   task automatic cfg(input logic [10:0] d);
      wr(HCU_MAIN_CTRL_OFS, d);
      wr(HCU_MAIN_CTRL_OFS, d | 11'h001);
   endtask : cfg
   task automatic load_now(input logic [10:0] keep);
      wr(HCU_MAIN_CTRL_OFS, keep | 11'h008);
   endtask : load_now
endmodule : hcu_host_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench of the main control block.
// Assumes: Design inputs change on the falling clock edge.
// Notes:   A register model in the bench predicts every control word read.
`timescale 1ns/100ps
module tb;
   import hcu_pkg::*;
   localparam int SW = HCU_NUM_PARAM*HCU_PARAM_W;
   localparam int DW = 2*HCU_PIX_W;
   logic          clk_sys_i = 1'b0;
   logic          nrst_i = 1'b0;
   logic          lock_event_i = 1'b0;
   logic          stir = 1'b0;
   logic          reg_wr_i, reg_rd_i, reg_rvalid_o;
   logic [7:0]    reg_addr_i;
   logic [10:0]   reg_wdata_i, reg_rdata_o;
   logic [SW-1:0] pending_set_i = '0;
   logic [SW-1:0] active_set_o;
   logic [3:0]    pins = 4'h0;
   logic [DW-1:0] port_a_data_i = '0, scaled_data_i = '0, display_data_o;
   logic [2:0]    port_a_ctrl_i = '0, timing_gen_ctrl_i = '0, display_ctrl_o;
   logic          input_pixel_clock_o, display_pixel_clock_o, input_rgb_mode_o;
   logic          input_port_b_sel_o, display_bypass_o, soft_reset_o, wire4_mode_o;
   logic          power_down_o;
   int            n_errors = 0;
   int            total_checks = 0;
   int            exp_ctrl = 0;
   hcu_main_ctrl hcu_main_ctrl_inst (
      .port_a_pixel_clock_i (pins[0]),
      .port_b_pixel_clock_i (pins[1]),
      .display_ref_clock_a_i(pins[2]),
      .display_ref_clock_b_i(pins[3]),
      .*
   );
   hcu_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
      .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   always #5 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) begin
      if (stir) begin
         pins <= 4'($urandom);
         {port_a_ctrl_i, timing_gen_ctrl_i} <= 6'($urandom);
         port_a_data_i <= DW'({$urandom, $urandom});
         scaled_data_i <= DW'({$urandom, $urandom});
      end
   end
   task automatic chk_bit(input logic e, input logic g, input string s);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: %s got %b expected %b", $time, s, g, e);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [10:0] e, input logic [10:0] g, input string s);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, s, g, e);
      end
   endtask : chk_word
   task automatic chk_wide(input logic [SW-1:0] e, input logic [SW-1:0] g, input string s);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: %s mismatch", $time, s);
      end
   endtask : chk_wide
   task automatic rd_chk();
      logic [10:0] got;
      host.rd(HCU_MAIN_CTRL_OFS, got);
      chk_word(exp_ctrl[10:0], got, "control word");
   endtask : rd_chk
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : wait_n
   task automatic pulse_lock();
      @(negedge clk_sys_i);
      lock_event_i = 1'b1;
      @(negedge clk_sys_i);
      lock_event_i = 1'b0;
   endtask : pulse_lock
   function automatic logic [SW-1:0] rand_set();
      logic [SW-1:0] r;
      for (int k = 0; k < SW / 32; k++) r[k*32+:32] = $urandom;
      return r;
   endfunction : rand_set
   task automatic wrap_up();
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial begin
      logic [10:0]   d;
      logic [10:0]   got;
      logic [SW-1:0] old;
      logic          sb;
      void'($urandom(32'hB100));
      wait_n(16);
      nrst_i = 1'b1;
      rd_chk();
      chk_bit(1'b1, input_port_b_sel_o, "port select");
      for (int i = 0; i < 8; i++) begin
         d = 11'($urandom) & 11'h6F6;
         {d[HCU_BIT_BYPASS], d[HCU_BIT_DREF_B], d[HCU_BIT_RGB]} = 3'(i);
         host.cfg(d);
         exp_ctrl = int'(d & 11'h6F2);
         stir <= 1'b1;
         wait_n(8);
         stir <= 1'b0;
         wait_n(5);
         sb = !d[HCU_BIT_RGB] | d[HCU_BIT_PORT_B];
         rd_chk();
         chk_bit(d[HCU_BIT_RGB], input_rgb_mode_o, "format");
         chk_bit(sb, input_port_b_sel_o, "port select");
         chk_bit(pins[sb] ^ d[HCU_BIT_CLK_INV], input_pixel_clock_o, "in clock");
         got[0] = d[HCU_BIT_BYPASS] ? pins[0] : pins[2 + d[HCU_BIT_DREF_B]];
         chk_bit(got[0], display_pixel_clock_o, "display clock");
         old = SW'(d[HCU_BIT_BYPASS] ? port_a_data_i : scaled_data_i);
         chk_wide(old, SW'(display_data_o), "pixels");
         old = SW'(d[HCU_BIT_BYPASS] ? port_a_ctrl_i : timing_gen_ctrl_i);
         chk_wide(old, SW'(display_ctrl_o), "controls");
         chk_bit(d[HCU_BIT_WIRE4], wire4_mode_o, "wire mode");
         chk_bit(d[HCU_BIT_PWRDWN], power_down_o, "power down");
      end
      pending_set_i = rand_set();
      host.load_now(exp_ctrl[10:0] | 11'h004);
      wait_n(6);
      chk_wide(pending_set_i, active_set_o, "forced copy");
      rd_chk();
      old = pending_set_i;
      pending_set_i = rand_set();
      pulse_lock();
      wait_n(5);
      chk_wide(old, active_set_o, "stale lock copy");
      host.wr(HCU_MAIN_CTRL_OFS, exp_ctrl[10:0] | 11'h004);
      wait_n(5);
      chk_wide(old, active_set_o, "early copy");
      pulse_lock();
      wait_n(5);
      chk_wide(pending_set_i, active_set_o, "lock copy");
      rd_chk();
      host.wr(8'h02, 11'h7FF);
      rd_chk();
      host.rd(8'h02, got);
      chk_word(11'h000, got, "unmapped read");
      @(negedge clk_sys_i);
      nrst_i = 1'b0;
      wait_n(3);
      nrst_i = 1'b1;
      exp_ctrl = 0;
      rd_chk();
      chk_bit(1'b0, input_rgb_mode_o, "format after hard reset");
      wrap_up();
   end
endmodule : tb
